/* File: design/rst_ctl_pkg.sv */
package rst_ctl_pkg;
	// clock
	localparam int unsigned CLK_PERIOD_NS = 10;
	// timing: power-on pulse least width, pin release spacing
	localparam int unsigned POR_PULSE_NS     = 150;
	localparam int unsigned POR_PULSE_CYCLES = (POR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned EXTERNAL_RESET_N_GAP_US      = 10;
	localparam int unsigned EXTERNAL_RESET_N_GAP_CYCLES  = (EXTERNAL_RESET_N_GAP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned HOLD_CYCLES      = 4;
	localparam int unsigned WDT_DEF_TIMEOUT  = 32'h0000_1000;

	// register byte addresses
	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_SWRST   = 8'h04;
	localparam logic [7:0] ADDR_WDT_CFG = 8'h08;
	localparam logic [7:0] ADDR_WDT_KICK = 8'h0c;
	localparam logic [7:0] ADDR_LVI_CFG = 8'h10;
	localparam logic [7:0] ADDR_STATUS  = 8'h14;
	localparam logic [7:0] ADDR_MON     = 8'h18;

	// ctrl field positions
	localparam int unsigned CTRL_SWRST_BLOCK = 0;
	localparam int unsigned CTRL_AREG_EN     = 1;
	localparam int unsigned CTRL_BUZZ_EN     = 2;
	localparam int unsigned CTRL_BUZZ_LO     = 8;
	localparam int unsigned CTRL_BUZZ_W      = 16;
	localparam int unsigned BUZZ_ON_CYCLES   = 4;
	localparam logic [15:0] BUZZ_DEF_PERIOD  = 16'h0100;

	// lvi cfg field positions (trip code 0 = 1.70 V, +250 mV per code, max 15 = 5.45 V)
	localparam int unsigned LVI_TRIP_W     = 4;
	localparam int unsigned LVI_D_TRIP_LO  = 0;
	localparam int unsigned LVI_A_TRIP_LO  = 4;
	localparam int unsigned LVI_D_EN       = 8;
	localparam int unsigned LVI_A_EN       = 9;
	localparam int unsigned LVI_H_EN       = 10;
	localparam int unsigned LVI_D_RESET    = 11;
	localparam int unsigned LVI_A_RESET    = 12;

	// status bits
	localparam int unsigned ST_W          = 7;
	localparam int unsigned ST_PRECISE_LOW_VOLTAGE_MONITOR       = 0;
	localparam int unsigned ST_EXTERNAL_RESET_N       = 1;
	localparam int unsigned ST_SOFTWARE_RESET_REQUEST       = 2;
	localparam int unsigned ST_WATCHDOG_RESET_REQUEST       = 3;
	localparam int unsigned ST_DIGITAL_LOW_VOLTAGE_IRQ       = 4;
	localparam int unsigned ST_ANALOG_LOW_VOLTAGE_IRQ       = 5;
	localparam int unsigned ST_ANALOG_HIGH_VOLTAGE_IRQ       = 6;

	// supply monitor comparator inputs from the analog side
	typedef struct packed {
		logic       por_n;
		logic       dig_reg_ok;
		logic       ana_reg_ok;
		logic       dig_supply_low;
		logic       ana_supply_low;
		logic       ana_supply_high;
	} supply_mon_s;

	// controls sent back to the analog monitors
	typedef struct packed {
		logic                  por_mon_en;
		logic                  precise_low_voltage_monitor_dig_en;
		logic                  precise_low_voltage_monitor_ana_en;
		logic                  lvi_en;
		logic [LVI_TRIP_W-1:0] dig_trip;
		logic [LVI_TRIP_W-1:0] ana_trip;
	} mon_ctrl_s;

	typedef enum logic [1:0] {
		PWR_ACTIVE    = 2'b00,
		PWR_SLEEP     = 2'b01,
		PWR_HIBERNATE = 2'b10
	} pwr_mode_e;
endpackage

/* File: design/rst_sync.sv */
`timescale 1ns/100ps
module rst_sync #(
	parameter int unsigned DEPTH = 3
) (
	// clock and raw reset request
	input  wire logic clk,
	input  wire logic async_rst_n,
	// synchronised release
	output logic      sync_rst_n
);
	typedef struct packed {
		logic [DEPTH-1:0] chain;
	} sync_state_s;

	sync_state_s state;
	sync_state_s next_state;

	always_comb begin
		next_state       = state;
		next_state.chain = {state.chain[DEPTH-2:0], 1'b1};
	end

	// assert at once, release only on a clock edge
	always_ff @(posedge clk or negedge async_rst_n) begin
		if (!async_rst_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign sync_rst_n = state.chain[DEPTH-1];
endmodule

/* File: design/pin_filter.sv */
`timescale 1ns/100ps
module pin_filter #(
	parameter logic RESET_VAL = 1'b1
) (
	// clock and reset
	input  wire logic hclk,
	input  wire logic hresetn,
	// raw pin and filtered level
	input  wire logic pin,
	output logic      level
);
	typedef struct packed {
		logic [2:0] sync;
		logic       level;
	} filt_state_s;

	filt_state_s state;
	filt_state_s next_state;

	always_comb begin
		next_state      = state;
		next_state.sync = {state.sync[1:0], pin};
		// first stage only feeds the second
		if (state.sync[1] == state.sync[2]) begin
			next_state.level = state.sync[2];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= {{3{RESET_VAL}}, RESET_VAL};
		end else begin
			state <= next_state;
		end
	end

	assign level = state.level;
endmodule

/* File: design/reset_source_controller.sv */
// Behaviour
// [RL1] any supply or regulator out of range resets the whole device
// [RL2] low and high voltage monitors can raise an interrupt before reset
// [RL3] device stays in reset while external reset pin is low
// [RL4] outside party waits 10 us after release before pulling pin again
// [RL5] external reset stays effective in sleep and hibernate
// [RL6] power-on reset pulse is at least 150 ns, longer while ramping; here a fixed POR_PULSE count, por_n is not used
// [RL7] after boot power-on monitor is disabled, precise monitor takes over
// [RL8] precise, pin and software resets act exactly like power-on reset
// [RL9] firmware cannot disable digital precise monitor; analog follows regulator
// [RL10] precise monitor off in sleep/hibernate, briefly on during sleep buzz
// [RL11] low voltage trips from 1.70 V in 250 mV steps; high fixed 5.75 V
// [RL12] each low voltage detector may reset instead of interrupting
// [RL13] voltage interrupt monitors idle until power-on reset completes
// [RL14] interrupt during buzz runs wakeup first, then presents interrupt
// [RL15] firmware keeps buzz period shorter than shortest supply excursion
// [RL16] writing one to software reset bit resets the device
// [RL17] a block bit stops the software reset bit from acting
// [RL18] watchdog resets device if not restarted within its timeout
// [RL19] power-on reset leaves watchdog disabled until firmware enables it
// [RL20] watchdog enable ignores zero writes, cleared only by power-on reset
// [RL21] status record captures reset and interrupt causes, cleared by power-on
// [RL22] device reset returns processor and all peripherals to reset state
// [RL23] reset requests combined and release synchronised to system clock
//
// Local design decisions: register access over AHB-Lite and the address map.
`timescale 1ns/100ps
module reset_source_controller
	import rst_ctl_pkg::*;
#(
	parameter int unsigned WDT_W           = 32,
	parameter int unsigned EXTERNAL_RESET_N_GAP        = EXTERNAL_RESET_N_GAP_CYCLES,
	parameter int unsigned POR_PULSE       = POR_PULSE_CYCLES
) (
	// system clock and power-on domain reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// pins and analog monitors
	input  wire logic        external_reset_n,
	input  wire supply_mon_s supply_mon,
	input  wire pwr_mode_e   pwr_mode,
	// power manager handshake
	output logic             wakeup_req,
	input  wire logic        wakeup_done,
	// monitor controls and results
	output mon_ctrl_s        mon_ctrl,
	output logic             voltage_irq,
	output logic             device_reset_n,
	output logic             buzz_active
);
	typedef struct packed {
		logic              booted;
		logic [7:0]        por_cnt;
		logic [19:0]       gap_cnt;
		logic              external_reset_n_seen;
		logic              swrst_block;
		logic              areg_en;
		logic              buzz_en;
		logic [CTRL_BUZZ_W-1:0] buzz_period;
		logic [CTRL_BUZZ_W-1:0] buzz_cnt;
		logic              buzz;
		logic              wdt_en;
		logic [WDT_W-1:0]  wdt_timeout;
		logic [WDT_W-1:0]  wdt_cnt;
		logic [15:0]       lvi_cfg;
		logic [ST_W-1:0]   status;
		logic              irq_pend;
		logic              wake_req;
		logic              irq;
		logic [2:0]        hold_cnt;
		logic              dev_rst_req;
		logic              sw_req;
		logic              wd_req;
		logic              ph_valid;
		logic              ph_write;
		logic [7:0]        ph_addr;
		logic [31:0]       rdata;
	} ctl_state_s;

	ctl_state_s state;
	ctl_state_s next_state;

	logic      external_reset_n_level;
	logic      dev_rst_sync_n;
	logic      dev_rst_async_n;
	mon_ctrl_s next_mon;

	function automatic logic field(input logic [15:0] cfg, input int unsigned pos);
		field = cfg[pos];
	endfunction

	pin_filter #(
		.RESET_VAL (1'b1)
	) u_external_reset_n_filt (
		.hclk    (hclk),
		.hresetn (hresetn),
		.pin     (external_reset_n),
		.level   (external_reset_n_level)
	);

	// comparators are asynchronous to hclk; ok bits read low until settled,
	// harmless because every monitor waits for boot
	wire supply_mon_s mon_q;

	for (genvar i = 0; i < $bits(supply_mon_s); i++) begin : g_mon_filt
		pin_filter #(
			.RESET_VAL (1'b0)
		) u_mon_filt (
			.hclk    (hclk),
			.hresetn (hresetn),
			.pin     (supply_mon[i]),
			.level   (mon_q[i])
		);
	end

	// [RL23] combine and sync
	assign dev_rst_async_n = hresetn & ~state.dev_rst_req;

	rst_sync #(
		.DEPTH (3)
	) u_dev_rst (
		.clk         (hclk),
		.async_rst_n (dev_rst_async_n),
		.sync_rst_n  (dev_rst_sync_n)
	);

	logic sleep_mode;
	logic lp_mode;
	logic precise_low_voltage_monitor_live;
	logic precise_low_voltage_monitor_trip;
	logic d_lvi;
	logic a_lvi;
	logic h_lvi;
	logic lvi_reset;
	logic lvi_irq_evt;
	logic ap_take;
	logic [ST_W-1:0] evt;

	always_comb begin
		sleep_mode = (pwr_mode == PWR_SLEEP);
		lp_mode    = (pwr_mode != PWR_ACTIVE);
		// [RL10] precise monitor gated by mode and buzz
		precise_low_voltage_monitor_live  = state.booted & (~lp_mode | (sleep_mode & state.buzz));
		// [RL9] digital part always on, analog tied to regulator
		precise_low_voltage_monitor_trip  = precise_low_voltage_monitor_live & (~mon_q.dig_reg_ok | (state.areg_en & ~mon_q.ana_reg_ok));
		// [RL13] monitors idle until boot
		d_lvi = state.booted & (~lp_mode | state.buzz) & field(state.lvi_cfg, LVI_D_EN) & mon_q.dig_supply_low;
		a_lvi = state.booted & (~lp_mode | state.buzz) & field(state.lvi_cfg, LVI_A_EN) & mon_q.ana_supply_low;
		h_lvi = state.booted & (~lp_mode | state.buzz) & field(state.lvi_cfg, LVI_H_EN) & mon_q.ana_supply_high;
		// [RL12] low voltage may reset instead
		lvi_reset   = (d_lvi & field(state.lvi_cfg, LVI_D_RESET)) | (a_lvi & field(state.lvi_cfg, LVI_A_RESET));
		// [RL2] interrupt path
		lvi_irq_evt = (d_lvi & ~field(state.lvi_cfg, LVI_D_RESET)) | (a_lvi & ~field(state.lvi_cfg, LVI_A_RESET)) | h_lvi;
		ap_take = hsel & hready & htrans[1];
		evt = '0;
		evt[ST_PRECISE_LOW_VOLTAGE_MONITOR] = precise_low_voltage_monitor_trip;
		evt[ST_EXTERNAL_RESET_N] = ~external_reset_n_level;
		evt[ST_SOFTWARE_RESET_REQUEST] = state.sw_req;
		evt[ST_WATCHDOG_RESET_REQUEST] = state.wd_req;
		evt[ST_DIGITAL_LOW_VOLTAGE_IRQ] = d_lvi;
		evt[ST_ANALOG_LOW_VOLTAGE_IRQ] = a_lvi;
		evt[ST_ANALOG_HIGH_VOLTAGE_IRQ] = h_lvi;
	end

	always_comb begin
		next_state = state;

		// [RL6] power-on pulse width
		if (state.por_cnt < 8'(POR_PULSE)) begin
			next_state.por_cnt = state.por_cnt + 8'h01;
		end else begin
			// [RL7] hand over to precise monitor
			next_state.booted = 1'b1;
		end

		// [RL4] watch the pin release spacing
		if (external_reset_n_level && state.gap_cnt < 20'(EXTERNAL_RESET_N_GAP)) begin
			next_state.gap_cnt = state.gap_cnt + 20'h00001;
		end else if (!external_reset_n_level) begin
			next_state.gap_cnt = '0;
		end

		// sleep buzz timer; period kept under shortest excursion by firmware
		if (sleep_mode && state.buzz_en) begin
			if (state.buzz_cnt >= state.buzz_period) begin
				next_state.buzz_cnt = '0;
				next_state.buzz     = 1'b1;
			end else begin
				next_state.buzz_cnt = state.buzz_cnt + 16'h0001;
				// window opens at count 0, so it closes one short
				if (state.buzz_cnt == 16'(BUZZ_ON_CYCLES - 1)) begin
					next_state.buzz = 1'b0;
				end
			end
		end else begin
			next_state.buzz_cnt = '0;
			next_state.buzz     = 1'b0;
		end

		// [RL14] wake first, then present interrupt
		if (lvi_irq_evt) begin
			next_state.irq_pend = 1'b1;
		end
		if (state.irq_pend && lp_mode) begin
			next_state.wake_req = 1'b1;
		end
		if (state.irq_pend && (!lp_mode || wakeup_done)) begin
			next_state.irq      = 1'b1;
			next_state.irq_pend = 1'b0;
			next_state.wake_req = 1'b0;
		end

		// [RL18] watchdog timeout
		next_state.wd_req = 1'b0;
		if (state.wdt_en) begin
			if (state.wdt_cnt >= state.wdt_timeout) begin
				next_state.wd_req  = 1'b1;
				next_state.wdt_cnt = '0;
			end else begin
				next_state.wdt_cnt = state.wdt_cnt + 1'b1;
			end
		end
		next_state.sw_req = 1'b0;

		// ahb data phase
		next_state.ph_valid = ap_take;
		if (ap_take) begin
			next_state.ph_write = hwrite;
			next_state.ph_addr  = haddr[7:0];
		end
		if (state.ph_valid && state.ph_write) begin
			case (state.ph_addr)
				ADDR_CTRL: begin
					next_state.swrst_block = hwdata[CTRL_SWRST_BLOCK];
					next_state.areg_en     = hwdata[CTRL_AREG_EN];
					next_state.buzz_en     = hwdata[CTRL_BUZZ_EN];
					next_state.buzz_period = hwdata[CTRL_BUZZ_LO +: CTRL_BUZZ_W];
				end
				ADDR_SWRST: begin
					// [RL16] [RL17] blockable software reset
					next_state.sw_req = hwdata[0] & ~state.swrst_block;
				end
				ADDR_WDT_CFG: begin
					// [RL20] enable is sticky
					next_state.wdt_en      = state.wdt_en | hwdata[0];
					next_state.wdt_timeout = hwdata[WDT_W-1:0];
				end
				ADDR_WDT_KICK: begin
					next_state.wdt_cnt = '0;
				end
				ADDR_LVI_CFG: begin
					// [RL11] trip codes, 250 mV per step
					next_state.lvi_cfg = hwdata[15:0];
				end
				ADDR_STATUS: begin
					// write-one-to-clear; irq cleared too
					next_state.status = state.status & ~hwdata[ST_W-1:0];
					next_state.irq    = state.irq & ~(|hwdata[ST_W-1:0]);
				end
				default: begin
				end
			endcase
		end
		if (ap_take && !hwrite) begin
			case (haddr[7:0])
				ADDR_CTRL:     next_state.rdata = {8'h00, state.buzz_period, 5'h00, state.buzz_en, state.areg_en,
				                                   state.swrst_block};
				ADDR_WDT_CFG:  next_state.rdata = 32'(state.wdt_timeout) | 32'(state.wdt_en);
				ADDR_WDT_KICK: next_state.rdata = 32'(state.wdt_cnt);
				ADDR_LVI_CFG:  next_state.rdata = {16'h0000, state.lvi_cfg};
				ADDR_STATUS:   next_state.rdata = 32'(state.status);
				ADDR_MON:      next_state.rdata = {26'h0000000, state.gap_cnt >= 20'(EXTERNAL_RESET_N_GAP), state.irq,
				                                   state.buzz, state.booted, external_reset_n_level, state.wdt_en};
				default:       next_state.rdata = 32'h0000_0000;
			endcase
		end

		// [RL21] [RL2] sticky causes, set wins over clear
		next_state.status = next_state.status | evt;
		if (lvi_irq_evt) begin
			next_state.irq_pend = 1'b1;
		end

		// [RL1] [RL3] [RL5] [RL6] [RL8] [RL12] combine reset sources, held a few cycles
		if (!state.booted || precise_low_voltage_monitor_trip || !external_reset_n_level || state.sw_req || state.wd_req || lvi_reset) begin
			next_state.dev_rst_req = 1'b1;
			next_state.hold_cnt    = 3'(HOLD_CYCLES);
		end else if (state.hold_cnt != 3'h0) begin
			next_state.hold_cnt = state.hold_cnt - 3'h1;
		end else begin
			next_state.dev_rst_req = 1'b0;
		end

		next_mon.por_mon_en  = ~state.booted;
		next_mon.precise_low_voltage_monitor_dig_en = precise_low_voltage_monitor_live;
		next_mon.precise_low_voltage_monitor_ana_en = precise_low_voltage_monitor_live & state.areg_en;
		next_mon.lvi_en      = state.booted & (~lp_mode | state.buzz);
		next_mon.dig_trip    = state.lvi_cfg[LVI_D_TRIP_LO +: LVI_TRIP_W];
		next_mon.ana_trip    = state.lvi_cfg[LVI_A_TRIP_LO +: LVI_TRIP_W];
	end

	// [RL19] [RL21] power-on clears watchdog enable and status
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state             <= '0;
			state.areg_en     <= 1'b1;
			state.buzz_period <= BUZZ_DEF_PERIOD;
			state.wdt_timeout <= WDT_W'(WDT_DEF_TIMEOUT);
			state.dev_rst_req <= 1'b1;
			mon_ctrl          <= '0;
		end else begin
			state    <= next_state;
			mon_ctrl <= next_mon;
		end
	end

	logic dev_rst_q;
	// [RL22] device reset out, registered
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dev_rst_q <= 1'b0;
		end else begin
			dev_rst_q <= dev_rst_sync_n;
		end
	end

	assign device_reset_n = dev_rst_q;
	assign hrdata         = state.rdata;
	assign hreadyout      = 1'b1;
	assign hresp          = 1'b0;
	assign voltage_irq    = state.irq;
	assign wakeup_req     = state.wake_req;
	assign buzz_active    = state.buzz;
endmodule

/* File: bench/reset_source_controller_props.sv */
`timescale 1ns/100ps
module reset_source_controller_props
	import rst_ctl_pkg::*;
#(
	parameter int unsigned POR_PULSE = POR_PULSE_CYCLES
) (
	// clock and power-on reset
	input wire logic        hclk,
	input wire logic        hresetn,
	// pin and monitors
	input wire logic        external_reset_n,
	input wire supply_mon_s supply_mon,
	input wire pwr_mode_e   pwr_mode,
	input wire logic        wakeup_done,
	// results
	input wire mon_ctrl_s   mon_ctrl,
	input wire logic        voltage_irq,
	input wire logic        device_reset_n,
	input wire logic        buzz_active
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic [7:0] cyc;
	// cycles since power-on release, saturating
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			cyc <= 8'h00;
		else if (cyc != 8'hff)
			cyc <= cyc + 8'h01;
	end
	sequence s_pin_low;
		!external_reset_n [*3];
	endsequence
	sequence s_trip;
		(mon_ctrl.precise_low_voltage_monitor_dig_en && !supply_mon.dig_reg_ok) [*3];
	endsequence
	property p_pin_rst;
		s_pin_low |-> ##[0:10] !device_reset_n;
	endproperty
	a_pin_rst: assert property (p_pin_rst) else $error("pin low gave no reset");
	property p_pin_hold;
		s_pin_low ##1 !external_reset_n [*8] |-> !device_reset_n;
	endproperty
	a_pin_hold: assert property (p_pin_hold) else $error("reset left while pin low");
	property p_rel_hold;
		$rose(external_reset_n) && !device_reset_n |=> !device_reset_n [*3];
	endproperty
	a_rel_hold: assert property (p_rel_hold) else $error("release not synchronised");
	property p_precise_low_voltage_monitor;
		s_trip |-> ##[0:10] !device_reset_n;
	endproperty
	a_precise_low_voltage_monitor: assert property (p_precise_low_voltage_monitor) else $error("regulator fault gave no reset");
	property p_precise_low_voltage_monitor_on;
		(cyc > POR_PULSE + 3 && pwr_mode == PWR_ACTIVE && !mon_ctrl.por_mon_en) [*3] |-> mon_ctrl.precise_low_voltage_monitor_dig_en;
	endproperty
	a_precise_low_voltage_monitor_on: assert property (p_precise_low_voltage_monitor_on) else $error("digital monitor off in active");
	property p_handover;
		$fell(mon_ctrl.por_mon_en) && pwr_mode == PWR_ACTIVE |-> ##[0:2] mon_ctrl.precise_low_voltage_monitor_dig_en;
	endproperty
	a_handover: assert property (p_handover) else $error("no handover to precise monitor");
	property p_hib_off;
		pwr_mode == PWR_HIBERNATE [*2] |-> !mon_ctrl.precise_low_voltage_monitor_dig_en;
	endproperty
	a_hib_off: assert property (p_hib_off) else $error("precise monitor on in hibernate");
	property p_buzz;
		$rose(buzz_active) |-> buzz_active [*4] ##1 !buzz_active;
	endproperty
	a_buzz: assert property (p_buzz) else $error("buzz window length wrong");
	property p_irq_gate;
		cyc < POR_PULSE |-> !voltage_irq && !mon_ctrl.lvi_en;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("monitor active before boot");
	property p_wake;
		(pwr_mode == PWR_SLEEP && !wakeup_done) [*2] |-> !$rose(voltage_irq);
	endproperty
	a_wake: assert property (p_wake) else $error("interrupt before wakeup");
endmodule

bind reset_source_controller reset_source_controller_props #(.POR_PULSE(POR_PULSE)) i_props (
	.hclk(hclk), .hresetn(hresetn), .external_reset_n(external_reset_n), .supply_mon(supply_mon),
	.pwr_mode(pwr_mode), .wakeup_done(wakeup_done), .mon_ctrl(mon_ctrl), .voltage_irq(voltage_irq),
	.device_reset_n(device_reset_n), .buzz_active(buzz_active)
);

/* File: bench/supply_pin_model.sv */
`timescale 1ns/100ps
module supply_pin_model
	import rst_ctl_pkg::*;
#(
	parameter int unsigned GAP = 10
) (
	// clock
	input  wire logic        hclk,
	// wishes of the bench
	input  wire logic        pin_req,
	input  wire supply_mon_s sreq,
	// towards the block
	output logic             external_reset_n,
	output supply_mon_s      supply_mon
);
	int unsigned since_rel;
	initial begin
		external_reset_n = 1'b1;
		since_rel = GAP;
	end
	// no new press before the gap has run out
	always @(posedge hclk) begin
		if (!external_reset_n && !pin_req) begin
			external_reset_n <= 1'b1;
			since_rel <= 0;
		end else if (external_reset_n && pin_req && since_rel >= GAP)
			external_reset_n <= 1'b0;
		else if (since_rel < GAP)
			since_rel <= since_rel + 1;
	end
	// comparator levels; power-on output is unused by the block
	always_comb begin
		supply_mon = sreq;
		supply_mon.por_n = 1'b1;
	end
endmodule

/* File: bench/reset_source_controller_tb.sv */
`timescale 1ns/100ps
module reset_source_controller_tb
	import rst_ctl_pkg::*;
;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'b00;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic        hready;
	logic [31:0] hrdata;
	logic        pin_req = 1'b0;
	logic        wakeup_done = 1'b0;
	logic        ext_n, wakeup_req, voltage_irq, device_reset_n, buzz_active;
	pwr_mode_e   pwr_mode = PWR_ACTIVE;
	supply_mon_s sreq = 6'b111000;
	supply_mon_s supply_mon;
	mon_ctrl_s   mon_ctrl;
	int          mismatches = 0;
	int          cmp_count = 0;
	always #5 hclk = ~hclk;
	reset_source_controller #(.EXTERNAL_RESET_N_GAP(10)) i_reset_source_controller (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'b010), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(),
		.external_reset_n(ext_n), .supply_mon(supply_mon), .pwr_mode(pwr_mode), .wakeup_req(wakeup_req),
		.wakeup_done(wakeup_done), .mon_ctrl(mon_ctrl), .voltage_irq(voltage_irq),
		.device_reset_n(device_reset_n), .buzz_active(buzz_active)
	);
	supply_pin_model #(.GAP(10)) i_supply_pin_model (
		.hclk(hclk), .pin_req(pin_req), .sreq(sreq), .external_reset_n(ext_n), .supply_mon(supply_mon)
	);
	task automatic tick(input int n);
		repeat (n) @(posedge hclk);
	endtask
	task automatic chk(input logic [31:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cb(input logic got, exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask
	function automatic logic pick(input int s);
		case (s)
			0: return device_reset_n;
			1: return voltage_irq;
			2: return buzz_active;
			default: return wakeup_req;
		endcase
	endfunction
	task automatic waitl(input int s, input logic lvl);
		int n;
		n = 0;
		while (pick(s) !== lvl && n < 200) begin
			n++;
			@(posedge hclk);
		end
		cb(pick(s), lvl);
	endtask
	// one single transfer; data taken at the closing edge
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr <= {24'h0, a};
		@(posedge hclk);
		while (hready !== 1'b1)
			@(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge hclk);
		while (hready !== 1'b1)
			@(posedge hclk);
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask
	task automatic t_por();
		rdchk(ADDR_STATUS, 32'h0);
		rdchk(ADDR_CTRL, 32'h0001_0002);
		rdchk(ADDR_WDT_CFG, WDT_DEF_TIMEOUT);
		rdchk(8'h1c, 32'h0);
		rdchk(ADDR_MON, 32'h0000_0026);
		cb(mon_ctrl.por_mon_en, 1'b0);
		cb(mon_ctrl.precise_low_voltage_monitor_dig_en, 1'b1);
	endtask
	task automatic t_pin();
		pwr_mode <= PWR_HIBERNATE;
		pin_req <= 1'b1;
		tick(20);
		cb(device_reset_n, 1'b0);
		pin_req <= 1'b0;
		pwr_mode <= PWR_ACTIVE;
		waitl(0, 1'b1);
		rdchk(ADDR_STATUS, 32'h2);
		wr(ADDR_STATUS, 32'h7f);
		rdchk(ADDR_STATUS, 32'h0);
	endtask
	task automatic t_sw();
		wr(ADDR_SWRST, 32'h1);
		waitl(0, 1'b0);
		waitl(0, 1'b1);
		rdchk(ADDR_STATUS, 32'h4);
		wr(ADDR_STATUS, 32'h7f);
		wr(ADDR_CTRL, 32'h0001_0003);
		wr(ADDR_SWRST, 32'h1);
		tick(20);
		cb(device_reset_n, 1'b1);
		rdchk(ADDR_STATUS, 32'h0);
		wr(ADDR_CTRL, 32'h0001_0000);
		tick(2);
		cb(mon_ctrl.precise_low_voltage_monitor_ana_en, 1'b0);
		cb(mon_ctrl.precise_low_voltage_monitor_dig_en, 1'b1);
		wr(ADDR_CTRL, 32'h0001_0002);
	endtask
	task automatic t_precise_low_voltage_monitor();
		sreq.dig_reg_ok <= 1'b0;
		waitl(0, 1'b0);
		sreq.dig_reg_ok <= 1'b1;
		waitl(0, 1'b1);
		rdchk(ADDR_STATUS, 32'h1);
		wr(ADDR_STATUS, 32'h7f);
	endtask
	task automatic t_lvi();
		wr(ADDR_LVI_CFG, 32'h0000_0753);
		tick(2);
		chk({24'h0, mon_ctrl.ana_trip, mon_ctrl.dig_trip}, 32'h53);
		sreq.ana_supply_high <= 1'b1;
		waitl(1, 1'b1);
		sreq.ana_supply_high <= 1'b0;
		tick(5);
		rdchk(ADDR_STATUS, 32'h40);
		wr(ADDR_STATUS, 32'h7f);
		waitl(1, 1'b0);
		wr(ADDR_LVI_CFG, 32'h0000_0953);
		sreq.dig_supply_low <= 1'b1;
		waitl(0, 1'b0);
		sreq.dig_supply_low <= 1'b0;
		waitl(0, 1'b1);
		wr(ADDR_STATUS, 32'h7f);
	endtask
	task automatic t_sleep();
		wr(ADDR_CTRL, 32'h0000_1006);
		wr(ADDR_LVI_CFG, 32'h0000_0200);
		pwr_mode <= PWR_SLEEP;
		waitl(2, 1'b1);
		sreq.ana_supply_low <= 1'b1;
		waitl(3, 1'b1);
		cb(voltage_irq, 1'b0);
		wakeup_done <= 1'b1;
		waitl(1, 1'b1);
		pwr_mode <= PWR_ACTIVE;
		wakeup_done <= 1'b0;
		sreq.ana_supply_low <= 1'b0;
		wr(ADDR_LVI_CFG, 32'h0);
		wr(ADDR_STATUS, 32'h7f);
		wr(ADDR_CTRL, 32'h0001_0002);
	endtask
	task automatic t_wdt();
		wr(ADDR_WDT_CFG, 32'h0000_0041);
		wr(ADDR_WDT_CFG, 32'h0000_0040);
		rdchk(ADDR_WDT_CFG, 32'h0000_0041);
		repeat (4) begin
			tick(40);
			wr(ADDR_WDT_KICK, 32'h0);
			cb(device_reset_n, 1'b1);
		end
		waitl(0, 1'b0);
		rdchk(ADDR_STATUS, 32'h8);
		hresetn <= 1'b0;
		tick(2);
		hresetn <= 1'b1;
		waitl(0, 1'b1);
		rdchk(ADDR_WDT_CFG, WDT_DEF_TIMEOUT);
		rdchk(ADDR_STATUS, 32'h0);
	endtask
	task automatic conclude();
		$display("mismatches %0d compares %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// run takes a few thousand cycles at most
	initial begin
		tick(20000);
		mismatches++;
		conclude();
	end
	initial begin
		tick(6);
		hresetn <= 1'b1;
		tick(POR_PULSE_CYCLES);
		cb(device_reset_n, 1'b0);
		waitl(0, 1'b1);
		t_por();
		t_pin();
		t_sw();
		t_precise_low_voltage_monitor();
		t_lvi();
		t_sleep();
		t_wdt();
		conclude();
	end
endmodule
